/* csec_pkg.sv */
// constants and carrier types for the channel status and error tally block
package csec_pkg;

  // management addressing
  localparam logic [4:0]  CSEC_DEVAD       = 5'h1e;
  localparam logic [15:0] CSEC_STATUS_ADDR = 16'h000f;
  localparam logic [15:0] CSEC_TALLY_ADDR  = 16'h0010;

  // reset values, tally full scale and zero
  localparam logic [15:0] CSEC_STATUS_RST  = 16'h0000;
  localparam logic [15:0] CSEC_TALLY_RST   = 16'hfffd;
  localparam logic [15:0] CSEC_TALLY_MAX   = 16'hffff;
  localparam logic [15:0] CSEC_ZERO        = 16'h0000;

  // widths
  localparam int CSEC_CNTW = 16;
  localparam int CSEC_ERRW = 4;

  // status field positions
  localparam int CSEC_B_ALIGN    = 15;
  localparam int CSEC_B_LOST     = 13;
  localparam int CSEC_B_AZ       = 12;
  localparam int CSEC_B_AGC      = 11;
  localparam int CSEC_B_SYNC     = 10;
  localparam int CSEC_B_CODE     = 8;
  localparam int CSEC_B_TX_UNDER = 7;
  localparam int CSEC_B_TX_OVER  = 6;
  localparam int CSEC_B_RX_UNDER = 5;
  localparam int CSEC_B_RX_OVER  = 4;
  localparam int CSEC_B_RX_LINK  = 3;
  localparam int CSEC_B_LANE     = 2;
  localparam int CSEC_B_LS_PLL   = 1;
  localparam int CSEC_B_HS_PLL   = 0;

  // analog and serdes levels, asynchronous to ref_clk_i
  typedef struct packed {
    logic high_side_signal_lost;
    logic autozero_finished;
    logic gain_loop_locked;
    logic channel_synced;
    logic system_rx_link_up;
    logic lane_align_link_up;
    logic low_side_pll_locked;
    logic high_side_pll_locked;
  } csec_lvl_s;

  // datapath event pulses, synchronous to ref_clk_i
  typedef struct packed {
    logic code_violation_seen;
    logic tx_underflow;
    logic tx_overflow;
    logic rx_underflow;
    logic rx_overflow;
  } csec_evt_s;

endpackage : csec_pkg

/* csec_err_tally.sv */
// saturating clear-on-read error tally
`timescale 1ns/1ps
`default_nettype none
module csec_err_tally (
  // clock and reset
  input  wire logic                          ref_clk_i,
  input  wire logic                          arst_n_i,
  // control
  input  wire logic                          clear_i,
  input  wire logic [csec_pkg::CSEC_ERRW-1:0] inc_i,
  // value
  output logic      [csec_pkg::CSEC_CNTW-1:0] count_o
);

  logic [csec_pkg::CSEC_CNTW-1:0] count;
  logic [csec_pkg::CSEC_CNTW-1:0] next_count;
  logic [csec_pkg::CSEC_CNTW-1:0] base;
  logic [csec_pkg::CSEC_CNTW:0]   sum;

  // an error in the read cycle is kept: it lands on the cleared value
  always_comb begin
    base       = clear_i ? csec_pkg::CSEC_ZERO : count;
    sum        = {1'b0, base} + {{(csec_pkg::CSEC_CNTW + 1 - csec_pkg::CSEC_ERRW){1'b0}}, inc_i};
    next_count = sum[csec_pkg::CSEC_CNTW] ? csec_pkg::CSEC_TALLY_MAX
                                          : sum[csec_pkg::CSEC_CNTW-1:0]; // saturate, no wrap
  end

  // register
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      count <= csec_pkg::CSEC_TALLY_RST;
    end else begin
      count <= next_count;
    end
  end

  assign count_o = count;

endmodule : csec_err_tally
`default_nettype wire

/* csec_channel_status.sv */
// channel health status register and high-side error tally
`timescale 1ns/1ps
`default_nettype none
module csec_channel_status (
  // clock and reset
  input  wire logic                           ref_clk_i,
  input  wire logic                           arst_n_i,
  // management register read port
  input  wire logic                           reg_rd_i,
  input  wire logic [4:0]                     reg_devad_i,
  input  wire logic [15:0]                    reg_addr_i,
  output logic      [15:0]                    rdata_o,
  output logic                                rvalid_o,
  output logic                                rhit_o,
  // asynchronous condition levels and pin
  input  wire csec_pkg::csec_lvl_s            lvl_i,
  input  wire logic                           pseudo_random_check_pin_i,
  // same-clock datapath events and modes
  input  wire csec_pkg::csec_evt_s            evt_i,
  input  wire logic                           decoder_en_i,
  input  wire logic                           jitter_verify_i,
  input  wire logic                           tp_verify_i,
  input  wire logic                           tp_aligned_i,
  input  wire logic                           tp_pattern_ok_i,
  input  wire logic [csec_pkg::CSEC_ERRW-1:0] tp_err_i,
  input  wire logic [csec_pkg::CSEC_ERRW-1:0] prbs_err_i
);

  // synchroniser stages; stage one feeds stage two only
  csec_pkg::csec_lvl_s lvl_s1;
  csec_pkg::csec_lvl_s lvl_s2;
  logic                prbs_s1;
  logic                prbs_s2;

  // latched status state
  logic       lost_latch;
  logic       az_latch;
  logic       link_latch;
  logic [4:0] evt_latch;
  logic       next_lost_latch;
  logic       next_az_latch;
  logic       next_link_latch;
  logic [4:0] next_evt_latch;

  // read path
  logic        rd_status;
  logic        rd_tally;
  logic        rd_hit;
  logic [15:0] status_word;
  logic [15:0] tally;
  logic [15:0] rdata;
  logic        rvalid;
  logic        rhit;
  logic [15:0] next_rdata;
  logic        next_rvalid;
  logic        next_rhit;
  logic        code_evt;
  logic [csec_pkg::CSEC_ERRW-1:0] inc_amt;

  // two flops for every level that crosses in from outside
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      lvl_s1  <= '0;
      lvl_s2  <= '0;
      prbs_s1 <= 1'b0;
      prbs_s2 <= 1'b0;
    end else begin
      lvl_s1  <= lvl_i;
      lvl_s2  <= lvl_s1;
      prbs_s1 <= pseudo_random_check_pin_i;
      prbs_s2 <= prbs_s1;
    end
  end

  // address decode on the management device and register number
  always_comb begin
    rd_hit    = reg_rd_i && (reg_devad_i == csec_pkg::CSEC_DEVAD);
    rd_status = rd_hit && (reg_addr_i == csec_pkg::CSEC_STATUS_ADDR);
    rd_tally  = rd_hit && (reg_addr_i == csec_pkg::CSEC_TALLY_ADDR);
  end

  // code violations only mean something with decoder or jitter check on
  assign code_evt = evt_i.code_violation_seen && (decoder_en_i || jitter_verify_i);

  // latch update: a condition arriving in the read cycle wins over the clear
  always_comb begin
    next_lost_latch = lvl_s2.high_side_signal_lost
                      || (lost_latch && !rd_status);
    next_az_latch   = lvl_s2.autozero_finished
                      && (az_latch || rd_status);
    next_link_latch = lvl_s2.system_rx_link_up
                      && (link_latch || rd_status);
    next_evt_latch  = {code_evt, evt_i.tx_underflow, evt_i.tx_overflow,
                       evt_i.rx_underflow, evt_i.rx_overflow}
                      | (evt_latch & {5{!rd_status}});
  end

  // latched status registers; low-latching bits start low, as the reset word
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      lost_latch <= 1'b0;
      az_latch   <= 1'b0;
      link_latch <= 1'b0;
      evt_latch  <= 5'h00;
    end else begin
      lost_latch <= next_lost_latch;
      az_latch   <= next_az_latch;
      link_latch <= next_link_latch;
      evt_latch  <= next_evt_latch;
    end
  end

  // status word as software sees it; reserved bits read zero
  always_comb begin
    status_word = csec_pkg::CSEC_STATUS_RST;
    status_word[csec_pkg::CSEC_B_ALIGN]    = tp_verify_i && tp_aligned_i
                                             && tp_pattern_ok_i;
    status_word[csec_pkg::CSEC_B_LOST]     = lost_latch;
    status_word[csec_pkg::CSEC_B_AZ]       = az_latch;
    status_word[csec_pkg::CSEC_B_AGC]      = lvl_s2.gain_loop_locked;
    status_word[csec_pkg::CSEC_B_SYNC]     = lvl_s2.channel_synced;
    status_word[csec_pkg::CSEC_B_CODE]     = evt_latch[4];
    status_word[csec_pkg::CSEC_B_TX_UNDER] = evt_latch[3];
    status_word[csec_pkg::CSEC_B_TX_OVER]  = evt_latch[2];
    status_word[csec_pkg::CSEC_B_RX_UNDER] = evt_latch[1];
    status_word[csec_pkg::CSEC_B_RX_OVER]  = evt_latch[0];
    status_word[csec_pkg::CSEC_B_RX_LINK]  = link_latch;
    status_word[csec_pkg::CSEC_B_LANE]     = lvl_s2.lane_align_link_up;
    status_word[csec_pkg::CSEC_B_LS_PLL]   = lvl_s2.low_side_pll_locked;
    status_word[csec_pkg::CSEC_B_HS_PLL]   = lvl_s2.high_side_pll_locked;
  end

  // tally source: pin beats pattern check beats functional decoding
  always_comb begin
    if (prbs_s2) begin
      inc_amt = prbs_err_i;
    end else if (tp_verify_i) begin
      inc_amt = tp_err_i;
    end else if (decoder_en_i && evt_i.code_violation_seen) begin
      inc_amt = {{(csec_pkg::CSEC_ERRW - 1){1'b0}}, 1'b1};
    end else begin
      inc_amt = '0;
    end
  end

  // tally counter, cleared by its own read
  csec_err_tally u_tally (
    .ref_clk_i (ref_clk_i),
    .arst_n_i  (arst_n_i),
    .clear_i   (rd_tally),
    .inc_i     (inc_amt),
    .count_o   (tally)
  );

  // read data returns the value before the read's clear takes effect
  always_comb begin
    next_rvalid = reg_rd_i;
    next_rhit   = rd_status || rd_tally;
    if (rd_status) begin
      next_rdata = status_word;
    end else if (rd_tally) begin
      next_rdata = tally;
    end else begin
      next_rdata = csec_pkg::CSEC_ZERO; // unmapped reads answer zero
    end
  end

  // read data registers
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rdata  <= csec_pkg::CSEC_ZERO;
      rvalid <= 1'b0;
      rhit   <= 1'b0;
    end else begin
      rdata  <= next_rdata;
      rvalid <= next_rvalid;
      rhit   <= next_rhit;
    end
  end

  assign rdata_o  = rdata;
  assign rvalid_o = rvalid;
  assign rhit_o   = rhit;

  // checks
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!arst_n_i);

  a_align_report: assert property (
    rd_status |=> rdata_o[15] == $past(tp_verify_i && tp_aligned_i && tp_pattern_ok_i))
    else $error("pattern alignment bit wrong");

  a_lost_latch: assert property (
    (lvl_s2.high_side_signal_lost || lost_latch) && !rd_status |=> lost_latch)
    else $error("loss of signal not held");

  a_lost_release: assert property (
    rd_status && !lvl_s2.high_side_signal_lost |=> !lost_latch)
    else $error("loss of signal not released by read");

  a_az_low_hold: assert property (
    (!lvl_s2.autozero_finished || !az_latch) && !rd_status |=> !az_latch)
    else $error("auto-zero low not held");

  a_link_low_hold: assert property (
    !lvl_s2.system_rx_link_up ##1 (!rd_status)[*2] |=> !link_latch)
    else $error("receive link low not held");

  a_code_sticky: assert property (
    code_evt ##1 rd_status |=> rdata_o[8])
    else $error("code violation lost");

  a_fifo_flags: assert property (
    evt_i.tx_underflow || evt_i.tx_overflow |=> evt_latch[3] || evt_latch[2])
    else $error("transmit fifo flag missed");

  a_rx_fifo_flag: assert property (
    evt_i.rx_overflow ##1 rd_status |=> rdata_o[4])
    else $error("receive fifo overflow missed");

  a_live_plls: assert property (
    rd_status |=> rdata_o[1:0] == $past({lvl_s2.low_side_pll_locked, lvl_s2.high_side_pll_locked}))
    else $error("pll lock bits wrong");

  a_tally_clear: assert property (
    rd_tally && inc_amt == '0 |=> tally == 16'h0000 && rdata_o == $past(tally))
    else $error("tally not cleared on read");

  a_tally_count: assert property (
    !rd_tally && !prbs_s2 && !tp_verify_i && decoder_en_i && evt_i.code_violation_seen
    && tally < 16'hfff0 |=> tally == $past(tally) + 16'h0001)
    else $error("code violation not tallied");

  a_prbs_count: assert property (
    !rd_tally && prbs_s2 && tally < 16'hfff0
    |=> tally == $past(tally) + {12'h000, $past(prbs_err_i)})
    else $error("pseudo-random errors not tallied");

  a_unmapped_zero: assert property (
    reg_rd_i && !rd_status && !rd_tally |=> rdata_o == 16'h0000 && !rhit_o)
    else $error("unmapped read not zero");

  // live bits, release on read and tally bookkeeping
  a_gain_sync_live: assert property (
    rd_status |=> rdata_o[11:10] == $past({lvl_s2.gain_loop_locked, lvl_s2.channel_synced}))
    else $error("gain or sync bit wrong");

  a_lane_live: assert property (
    rd_status |=> rdata_o[2] == $past(lvl_s2.lane_align_link_up))
    else $error("lane alignment bit wrong");

  a_az_release: assert property (
    rd_status && lvl_s2.autozero_finished |=> az_latch)
    else $error("auto-zero not released by read");

  a_link_release: assert property (
    rd_status && lvl_s2.system_rx_link_up |=> link_latch)
    else $error("receive link not released by read");

  a_event_clear: assert property (
    rd_status && evt_i == '0 |=> evt_latch == 5'h00)
    else $error("event flags not cleared by read");

  a_code_gate: assert property (
    !evt_latch[4] && !code_evt |=> !evt_latch[4])
    else $error("code violation flag set without cause");

  a_tx_fifo_hold: assert property (
    evt_latch[3] && !rd_status |=> evt_latch[3])
    else $error("transmit underflow flag not held");

  a_rx_under_flag: assert property (
    evt_i.rx_underflow |=> evt_latch[1])
    else $error("receive underflow missed");

  a_pattern_count: assert property (
    !rd_tally && !prbs_s2 && tp_verify_i && tally < 16'hfff0
    |=> tally == $past(tally) + {12'h000, $past(tp_err_i)})
    else $error("pattern errors not tallied");

  a_tally_idle: assert property (
    !rd_tally && inc_amt == '0 |=> tally == $past(tally))
    else $error("tally moved without errors");

  a_tally_saturate: assert property (
    tally == 16'hffff && !rd_tally |=> tally == 16'hffff)
    else $error("tally wrapped past full scale");

  a_tally_reload: assert property (
    rd_tally |=> tally == {12'h000, $past(inc_amt)})
    else $error("tally not restarted from zero");

  a_read_answer: assert property (
    reg_rd_i |=> rvalid_o && rhit_o == $past(rd_status || rd_tally))
    else $error("read answer strobe or hit wrong");

  c_lost_read: cover property (lost_latch ##1 rd_status ##1 !lost_latch);
  c_pattern_count: cover property (tp_verify_i && tp_err_i != '0 && !prbs_s2 && !rd_tally);
  c_tally_sat: cover property (tally == 16'hffff ##1 rd_tally ##1 tally == 16'h0000);
  c_prbs_count: cover property (prbs_s2 && prbs_err_i != '0 && !rd_tally);
  c_az_recover: cover property (!az_latch ##1 rd_status ##1 az_latch);

endmodule : csec_channel_status
`default_nettype wire

/* csec_host_model.sv */
// management host model issuing single register reads
`timescale 1ns/1ps
`default_nettype none
module csec_host_model (
  // clock
  input  wire logic        ref_clk_i,
  // read answer
  input  wire logic [15:0] rdata_i,
  input  wire logic        rvalid_i,
  input  wire logic        rhit_i,
  // read request
  output var  logic        reg_rd_o,
  output var  logic [4:0]  reg_devad_o,
  output var  logic [15:0] reg_addr_o
);
  // idle lines; address parked on the inverse so no stale decode looks valid
  initial begin
    reg_rd_o    = 1'h0;
    reg_devad_o = 5'h00;
    reg_addr_o  = 16'hffff;
  end
  // one-cycle strobe, answer taken while rvalid stands
  task automatic rd(input logic [4:0] dev, input logic [15:0] adr,
                    output logic [15:0] dat, output logic hit, output logic ok);
    @(negedge ref_clk_i);
    reg_rd_o    = 1'h1;
    reg_devad_o = dev;
    reg_addr_o  = adr;
    @(negedge ref_clk_i);
    reg_rd_o    = 1'h0;
    reg_devad_o = ~dev;
    reg_addr_o  = ~adr;
    ok          = rvalid_i;
    dat         = rdata_i;
    hit         = rhit_i;
  endtask : rd
endmodule : csec_host_model
`default_nettype wire

/* tb.sv */
// self-checking bench for the channel status and error tally block
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic                ref_clk_i = 1'h0;
  logic                arst_n_i = 1'h0;
  logic                reg_rd_i;
  logic                rvalid_o;
  logic                rhit_o;
  logic [4:0]          reg_devad_i;
  logic [15:0]         reg_addr_i;
  logic [15:0]         rdata_o;
  csec_pkg::csec_lvl_s lvl_i = '0;
  csec_pkg::csec_evt_s evt_i = '0;
  logic                pin = 1'h0;
  logic                decoder_en_i = 1'h0;
  logic                jitter_verify_i = 1'h0;
  logic                tp_verify_i = 1'h0;
  logic                tp_aligned_i = 1'h0;
  logic                tp_pattern_ok_i = 1'h0;
  logic [3:0]          tp_err_i = 4'h0;
  logic [3:0]          prbs_err_i = 4'h0;
  int                  fail_count = 0;
  int                  num_checks = 0;

  // 50 MHz
  always #10 ref_clk_i = ~ref_clk_i;

  csec_channel_status u_dut (
    .ref_clk_i, .arst_n_i, .reg_rd_i, .reg_devad_i, .reg_addr_i, .rdata_o, .rvalid_o,
    .rhit_o, .lvl_i, .pseudo_random_check_pin_i(pin), .evt_i, .decoder_en_i,
    .jitter_verify_i, .tp_verify_i, .tp_aligned_i, .tp_pattern_ok_i, .tp_err_i, .prbs_err_i
  );
  csec_host_model u_host (
    .ref_clk_i, .rdata_i(rdata_o), .rvalid_i(rvalid_o), .rhit_i(rhit_o),
    .reg_rd_o(reg_rd_i), .reg_devad_o(reg_devad_i), .reg_addr_o(reg_addr_i)
  );

  // verdict, single exit point
  task automatic tally_and_finish();
    if (fail_count == 0 && num_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : tally_and_finish

  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    num_checks++;
    if (g !== e) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // read, then compare answer strobe, hit flag and data
  task automatic rdc(input string nm, input logic [4:0] dv, input logic [15:0] ad,
                     input logic [15:0] e, input logic eh);
    logic [15:0] d;
    logic        h;
    logic        v;
    u_host.rd(dv, ad, d, h, v);
    chk("answer", {14'h0, 1'h1, eh}, {14'h0, v, h});
    chk(nm, e, d);
  endtask : rdc

  task automatic st(input logic [15:0] e);
    rdc("status", csec_pkg::CSEC_DEVAD, csec_pkg::CSEC_STATUS_ADDR, e, 1'h1);
  endtask : st

  task automatic tl(input logic [15:0] e);
    rdc("tally", csec_pkg::CSEC_DEVAD, csec_pkg::CSEC_TALLY_ADDR, e, 1'h1);
  endtask : tl

  task automatic cyc(input int n);
    repeat (n) @(negedge ref_clk_i);
  endtask : cyc

  // one-cycle event pulse
  task automatic ev(input logic [4:0] m);
    @(negedge ref_clk_i);
    evt_i = m;
    @(negedge ref_clk_i);
    evt_i = '0;
  endtask : ev

  initial begin
    // watchdog: the sequence needs well under 1000 cycles
    fork
      begin
        repeat (5000) @(posedge ref_clk_i);
        fail_count++;
        tally_and_finish();
      end
    join_none
    cyc(6);
    arst_n_i = 1'h1;
    // refused reads leave the tally untouched
    rdc("stray", 5'h1d, csec_pkg::CSEC_TALLY_ADDR, 16'h0000, 1'h0);
    rdc("stray", csec_pkg::CSEC_DEVAD, 16'h0011, 16'h0000, 1'h0);
    tl(16'hfffd);
    tl(16'h0000);
    st(16'h0000);
    // latch-low bits stay low until the first read after the level rises
    lvl_i = 8'h7f;
    cyc(5);
    st(16'h0c07);
    st(16'h1c0f);
    lvl_i = 8'h37;
    cyc(3);
    lvl_i = 8'h7f;
    cyc(5);
    st(16'h0c07);
    st(16'h1c0f);
    lvl_i = 8'hff;
    cyc(3);
    lvl_i = 8'h7f;
    cyc(5);
    st(16'h3c0f);
    st(16'h1c0f);
    // fifo flags one at a time
    for (int i = 0; i < 4; i++) begin
      ev(5'h01 << i);
      cyc(3);
      st(16'h1c0f | (16'h0010 << i));
      st(16'h1c0f);
    end
    // code violations: counted only with the decoder on
    decoder_en_i = 1'h1;
    repeat (3) ev(5'h10);
    cyc(3);
    st(16'h1d0f);
    tl(16'h0003);
    decoder_en_i = 1'h0;
    ev(5'h10);
    cyc(3);
    st(16'h1c0f);
    jitter_verify_i = 1'h1;
    ev(5'h10);
    cyc(3);
    st(16'h1d0f);
    jitter_verify_i = 1'h0;
    tl(16'h0000);
    // pattern verification: two cycles of five errors
    tp_verify_i = 1'h1;
    tp_aligned_i = 1'h1;
    tp_pattern_ok_i = 1'h1;
    cyc(1);
    tp_err_i = 4'h5;
    cyc(2);
    tp_err_i = 4'h0;
    cyc(2);
    st(16'h9c0f);
    tl(16'h000a);
    tp_pattern_ok_i = 1'h0;
    st(16'h1c0f);
    // pin selects pseudo-random errors over pattern errors
    pin = 1'h1;
    cyc(3);
    prbs_err_i = 4'h7;
    tp_err_i = 4'h4;
    cyc(1);
    prbs_err_i = 4'h0;
    tp_err_i = 4'h0;
    cyc(3);
    tl(16'h0007);
    // mid-run reset; a burst right after it must saturate, not wrap
    arst_n_i = 1'h0;
    cyc(2);
    arst_n_i = 1'h1;
    cyc(3);
    prbs_err_i = 4'hf;
    cyc(1);
    prbs_err_i = 4'h0;
    tl(16'hffff);
    st(16'h0c07);
    tally_and_finish();
  end
endmodule : tb
`default_nettype wire
